// File: bench/tb_tw_wave_ctrl.sv
// self-checking testbench for the timer waveform mode control block
`timescale 1ns/1ps
module tb_tw_wave_ctrl import tw_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn, ce, timer_tick, psel, penable, pwrite, pin_dir_a, pin_dir_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, wave_out_a, wave_out_b, pin_oe_a, pin_oe_b, overflow_flag;
  int bad_count = 0;
  int tests_run = 0;
  int i;
  logic [1:0] code;
  // mode, start count, ticks, expected count, expected overflow
  int tbl [9][5] = '{'{0, 8'hFE, 2, 0, 1}, '{2, 1, 3, 0, 0}, '{2, 8'hFE, 2, 0, 1},
    '{3, 8'hFE, 2, 0, 1}, '{7, 2, 2, 0, 1}, '{1, 8'hFE, 257, 1, 1}, '{5, 1, 4, 1, 0},
    '{4, 7, 3, 7, 0}, '{6, 7, 3, 7, 0}};

  always #2.5 pclk = ~pclk;

  tw_wave_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .timer_tick(timer_tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_dir_a(pin_dir_a), .pin_dir_b(pin_dir_b), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .pin_oe_a(pin_oe_a), .pin_oe_b(pin_oe_b),
    .overflow_flag(overflow_flag)
  );

  task test_done;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // entered just after a rising edge; one idle cycle follows each transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask : rd

  task cfg(input logic [2:0] m, input logic [1:0] a, input logic [1:0] b);
    wr(TW_ADDR_CTRL_SECOND, {28'h0, m[2], 3'h0});
    wr(TW_ADDR_CTRL_FIRST, {24'h0, a, b, 2'h0, m[1:0]});
  endtask : cfg

  task ticks(input int n);
    timer_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'b0;
    @(posedge pclk);
  endtask : ticks

  task pins(input logic ea, input logic eb, input logic oa, input logic ob);
    @(negedge pclk);
    chk({30'h0, wave_out_a, wave_out_b}, {30'h0, ea, eb});
    chk({30'h0, pin_oe_a, pin_oe_b}, {30'h0, oa, ob});
    @(posedge pclk);
  endtask : pins

  task run(input int m, input int st, input int n, input int ec, input int eo);
    cfg(3'(m), 2'h0, 2'h0);
    wr(TW_ADDR_STATUS, 32'h1);
    wr(TW_ADDR_COUNT, 32'(st));
    ticks(n);
    rd(TW_ADDR_COUNT, 32'(ec));
    rd(TW_ADDR_STATUS, 32'(eo));
    chk({31'h0, overflow_flag}, 32'(eo));
  endtask : run

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    timer_tick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_dir_a = 1'b1;
    pin_dir_b = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TW_ADDR_CTRL_FIRST, 32'h0);
    rd(TW_ADDR_CTRL_SECOND, 32'h0);
    wr(TW_ADDR_CTRL_FIRST, 32'hFF);
    rd(TW_ADDR_CTRL_FIRST, 32'hF3);
    rd(8'h18, 32'h0, 1'b1);
    cfg(3'h0, 2'h0, 2'h0);
    wr(TW_ADDR_CMP_A, 32'h3);
    wr(TW_ADDR_CMP_B, 32'h3);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    // set, clear, then two toggles, each on a match at count 3
    for (i = 0; i < 4; i++) begin
      code = (i < 2) ? 2'(3 - i) : 2'h1;
      cfg(3'h0, code, code);
      wr(TW_ADDR_COUNT, 32'h2);
      ticks(2);
      pins(~i[0], ~i[0], 1'b1, 1'b1);
    end
    pin_dir_a <= 1'b0;
    @(posedge pclk);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    pin_dir_a <= 1'b1;
    for (i = 0; i < 9; i++) begin
      run(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4]);
    end
    // compare a buffered in mode 7: old top 3 still ends the cycle
    cfg(3'h7, 2'h0, 2'h0);
    wr(TW_ADDR_CMP_A, 32'h6);
    wr(TW_ADDR_COUNT, 32'h1);
    ticks(3);
    rd(TW_ADDR_COUNT, 32'h0);
    rd(TW_ADDR_CMP_A, 32'h6);
    cfg(3'h0, 2'h0, 2'h0);
    wr(TW_ADDR_CMP_A, 32'h10);
    wr(TW_ADDR_CMP_B, 32'h10);
    for (i = 2; i < 4; i++) begin
      cfg(3'h3, 2'(i), 2'(i));
      wr(TW_ADDR_COUNT, 32'hFE);
      ticks(2);
      pins(i == 2, i == 2, 1'b1, 1'b1);
      wr(TW_ADDR_COUNT, 32'h0F);
      ticks(2);
      pins(i == 3, i == 3, 1'b1, 1'b1);
    end
    cfg(3'h0, 2'h0, 2'h0);
    wr(TW_ADDR_CMP_A, 32'hFF);
    wr(TW_ADDR_CMP_B, 32'hFF);
    cfg(3'h3, 2'h3, 2'h3);
    wr(TW_ADDR_COUNT, 32'hFE);
    ticks(2);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    cfg(3'h0, 2'h0, 2'h0);
    wr(TW_ADDR_CMP_A, 32'h10);
    wr(TW_ADDR_CMP_B, 32'h10);
    cfg(3'h3, 2'h1, 2'h1);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    cfg(3'h7, 2'h1, 2'h1);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    wr(TW_ADDR_COUNT, 32'h0E);
    ticks(3);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    // a pass through bottom leaves the phase counter counting up
    for (i = 2; i < 4; i++) begin
      cfg(3'h1, 2'(i), 2'(i));
      wr(TW_ADDR_COUNT, 32'h2);
      ticks(3);
      wr(TW_ADDR_COUNT, 32'h0F);
      ticks(2);
      pins(i == 3, i == 3, 1'b1, 1'b1);
      wr(TW_ADDR_COUNT, 32'hFE);
      ticks(242);
      pins(i == 2, i == 2, 1'b1, 1'b1);
    end
    wr(TW_ADDR_COUNT, 32'h5);
    ce <= 1'b0;
    ticks(4);
    ce <= 1'b1;
    rd(TW_ADDR_COUNT, 32'h5);
    test_done();
  end
endmodule : tb_tw_wave_ctrl

// File: rtl/tw_out_unit.sv
// one compare output channel: action decode, output flop and pin enable
`timescale 1ns/1ps
module tw_out_unit import tw_pkg::*; #(
  parameter bit CHAN_A = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic tick,
  input tw_mode_class_type mode_class,
  input wire logic mode_hi,
  input wire logic [1:0] action,
  input tw_evt_type evt,
  input wire logic pin_dir,
  output logic wave_out,
  output logic pin_oe
);
  logic wave_r;
  logic oe_r;
  logic pwm;
  logic toggle_ok;
  logic connected;
  logic special;
  logic step;

  assign pwm = (mode_class == TW_MC_FAST) || (mode_class == TW_MC_PHASE);
  // only channel a may toggle in pwm, and only with the high mode bit set
  assign toggle_ok = !pwm || (CHAN_A && mode_hi);
  assign connected = (action != TW_ACT_OFF) && ((action != TW_ACT_TOGGLE) || toggle_ok);
  assign special = pwm && action[1] && evt.cmp_is_top;
  assign step = ce && tick;
  assign wave_out = wave_r;
  assign pin_oe = oe_r;

  // output register moves only on timer ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_r <= 1'b0;
    end else if (step) begin
      case (mode_class)
        TW_MC_NORMAL, TW_MC_CTC: begin
          if (evt.match) begin
            case (action)
              TW_ACT_TOGGLE: wave_r <= !wave_r;
              TW_ACT_CLEAR: wave_r <= 1'b0;
              TW_ACT_SET: wave_r <= 1'b1;
              default: wave_r <= wave_r;
            endcase
          end
        end
        TW_MC_FAST: begin
          if (action == TW_ACT_TOGGLE) begin
            if (toggle_ok && evt.match) begin
              wave_r <= !wave_r;
            end
          end else if (action[1]) begin
            if (evt.at_top) begin
              wave_r <= !action[0];
            end else if (evt.match && !special) begin
              wave_r <= action[0];
            end
          end
        end
        TW_MC_PHASE: begin
          if (action == TW_ACT_TOGGLE) begin
            if (toggle_ok && evt.match) begin
              wave_r <= !wave_r;
            end
          end else if (action[1]) begin
            // match ignored at top; the top step takes the down-count level
            if (special) begin
              if (evt.at_top) begin
                wave_r <= !action[0];
              end
            end else if (evt.match) begin
              wave_r <= evt.down ? !action[0] : action[0];
            end
          end
        end
        default: wave_r <= wave_r;
      endcase
    end
  end

  // enable follows action writes at once, not only ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 1'b0;
    end else if (ce) begin
      oe_r <= pin_dir && connected;
    end
  end

  no_dir_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !pin_dir |=> !pin_oe) else $error("pin driven with direction clear");
  off_action_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && action == TW_ACT_OFF |=> !pin_oe) else $error("pin driven with action off");
  np_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && evt.match && mode_class == TW_MC_NORMAL && action == TW_ACT_TOGGLE
    |=> wave_r != $past(wave_r)) else $error("no toggle on match");
  fast_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && mode_class == TW_MC_FAST && action == TW_ACT_CLEAR && evt.at_top
    |=> wave_r) else $error("fast pwm not set at top");
  phase_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && mode_class == TW_MC_PHASE && action == TW_ACT_CLEAR && evt.match
    && evt.down && !evt.cmp_is_top |=> wave_r) else $error("phase down match not set");
  ignore_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && pwm && action[1] && evt.cmp_is_top && evt.at_top
    |=> wave_r == !$past(action[0])) else $error("top action not taken");
  hold_notick_a: assert property (@(posedge pclk) disable iff (!presetn)
    !step |=> $stable(wave_r)) else $error("output moved without tick");
  cov_fast_c: cover property (@(posedge pclk) disable iff (!presetn)
    step && mode_class == TW_MC_FAST && evt.at_top && action[1]);
  cov_phase_c: cover property (@(posedge pclk) disable iff (!presetn)
    step && mode_class == TW_MC_PHASE && evt.match && evt.down);
endmodule : tw_out_unit

// File: rtl/tw_pkg.sv
// package of constants and types for the timer waveform mode control block
package tw_pkg;
  localparam logic [7:0] TW_ADDR_CTRL_FIRST = 8'h00;
  localparam logic [7:0] TW_ADDR_CTRL_SECOND = 8'h04;
  localparam logic [7:0] TW_ADDR_COUNT = 8'h08;
  localparam logic [7:0] TW_ADDR_CMP_A = 8'h0C;
  localparam logic [7:0] TW_ADDR_CMP_B = 8'h10;
  localparam logic [7:0] TW_ADDR_STATUS = 8'h14;
  localparam int TW_ACT_A_HI = 7;
  localparam int TW_ACT_A_LO = 6;
  localparam int TW_ACT_B_HI = 5;
  localparam int TW_ACT_B_LO = 4;
  localparam int TW_MODE_LOW_HI = 1;
  localparam int TW_MODE_LOW_LO = 0;
  localparam int TW_MODE_HI_BIT = 3;
  localparam int TW_OVF_BIT = 0;
  localparam logic [7:0] TW_CTRL_FIRST_RST = 8'h00;
  localparam logic [7:0] TW_CTRL_FIRST_WMASK = 8'hF3;
  localparam logic [7:0] TW_COUNT_RST = 8'h00;
  localparam logic [7:0] TW_CMP_RST = 8'h00;
  localparam logic [7:0] TW_TOP_FIXED = 8'hFF;
  localparam logic [7:0] TW_MAX = 8'hFF;
  localparam logic [7:0] TW_BOTTOM = 8'h00;
  localparam logic [1:0] TW_ACT_OFF = 2'h0;
  localparam logic [1:0] TW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TW_ACT_SET = 2'h3;
  typedef enum logic [2:0] {
    TW_MC_NORMAL = 3'b000,
    TW_MC_PHASE = 3'b001,
    TW_MC_CTC = 3'b010,
    TW_MC_FAST = 3'b011,
    TW_MC_RSVD = 3'b100
  } tw_mode_class_type;
  typedef struct packed {
    logic match;
    logic at_top;
    logic down;
    logic cmp_is_top;
  } tw_evt_type;
endpackage : tw_pkg

// File: rtl/tw_wave_ctrl.sv
// timer waveform mode control: apb registers, counter sequence and two outputs
//
// Operation
// - nonzero action field connects compare output to pin, except a pwm code 01 that may not toggle; zero disconnects it.
// - compare output drives pin only while pin direction bit selects output.
// - non-pwm output a: 00 off, 01 toggle, 10 clear, 11 set on match.
// - non-pwm output b: 00 off, 01 toggle, 10 clear, 11 set on match.
// - pwm code 01 toggles output a only with high mode bit set.
// - fast pwm a: 10 clears on match, sets at top; 11 opposite.
// - fast pwm b: 01 reserved; 10 clear on match, set at top; 11 opposite.
// - phase pwm a: 10 clears on up match, sets on down match; 11 opposite.
// - phase pwm b: 01 reserved; 10 and 11 as for output a.
// - pwm, compare a equals top, high bit set: ignore match, act at top.
// - pwm, compare b equals top, high bit set: ignore match, act at top.
// - first control bits 3:2 read zero; others read/write; reset zero.
// - mode is high bit from second control above first control bits 1:0.
// - modes 0 normal, 1/5 phase, 2 clear-on-match, 3/7 fast, 4/6 reserved.
// - top is 0xff in modes 0,1,3 and compare a in 2,5,7.
// - compare writes immediate in modes 0,2; buffered until top in pwm.
// - overflow at max in 0,2,3; at bottom in 1,5; at top in 7.
// - phase pwm counts up to top, then counts down from the next tick without holding.
// - fast pwm counts to top then clears to bottom next tick.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module tw_wave_ctrl import tw_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic timer_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_dir_a,
  input wire logic pin_dir_b,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic pin_oe_a,
  output logic pin_oe_b,
  output logic overflow_flag
);
  logic [7:0] ctrl_first_r;
  logic waveform_mode_hi_r;
  logic [7:0] count_value_r;
  logic down_r;
  logic block_r;
  logic [7:0] cmp_a_buf_r;
  logic [7:0] compare_value_a_r;
  logic [7:0] cmp_b_buf_r;
  logic [7:0] compare_value_b_r;
  logic ovf_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata_nxt;
  logic mapped;
  logic [2:0] waveform_mode_sel;
  tw_mode_class_type mode_class;
  logic [7:0] top_val;
  logic pwm;
  logic at_top;
  logic tick_en;
  logic wr_en;
  logic rd_fetch;
  logic ovf_set;
  logic [1:0] output_a_action;
  logic [1:0] output_b_action;
  tw_evt_type evt_a;
  tw_evt_type evt_b;

  assign waveform_mode_sel = {waveform_mode_hi_r,
                              ctrl_first_r[TW_MODE_LOW_HI:TW_MODE_LOW_LO]};
  assign output_a_action = ctrl_first_r[TW_ACT_A_HI:TW_ACT_A_LO];
  assign output_b_action = ctrl_first_r[TW_ACT_B_HI:TW_ACT_B_LO];

  always_comb begin
    case (waveform_mode_sel)
      3'h0: mode_class = TW_MC_NORMAL;
      3'h1, 3'h5: mode_class = TW_MC_PHASE;
      3'h2: mode_class = TW_MC_CTC;
      3'h3, 3'h7: mode_class = TW_MC_FAST;
      default: mode_class = TW_MC_RSVD;
    endcase
  end

  // top source; reserved modes fall back to the fixed top
  always_comb begin
    case (waveform_mode_sel)
      3'h2, 3'h5, 3'h7: top_val = compare_value_a_r;
      default: top_val = TW_TOP_FIXED;
    endcase
  end

  assign pwm = (mode_class == TW_MC_PHASE) || (mode_class == TW_MC_FAST);
  assign at_top = (count_value_r == top_val);
  assign tick_en = ce && timer_tick;
  assign wr_en = ce && psel && penable && pready_r && pwrite;
  assign rd_fetch = ce && psel && penable && !pready_r;

  always_comb begin
    mapped = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      TW_ADDR_CTRL_FIRST: rdata_nxt[7:0] = ctrl_first_r & TW_CTRL_FIRST_WMASK;
      TW_ADDR_CTRL_SECOND: rdata_nxt[TW_MODE_HI_BIT] = waveform_mode_hi_r;
      TW_ADDR_COUNT: rdata_nxt[7:0] = count_value_r;
      TW_ADDR_CMP_A: rdata_nxt[7:0] = cmp_a_buf_r;
      TW_ADDR_CMP_B: rdata_nxt[7:0] = cmp_b_buf_r;
      TW_ADDR_STATUS: rdata_nxt[TW_OVF_BIT] = ovf_r;
      default: mapped = 1'b0;
    endcase
  end

  // one wait state: answer comes one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      pready_r <= rd_fetch;
      if (rd_fetch) begin
        pslverr_r <= !mapped;
        prdata_r <= (pwrite || !mapped) ? 32'h0000_0000 : rdata_nxt;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_first_r <= TW_CTRL_FIRST_RST;
      waveform_mode_hi_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == TW_ADDR_CTRL_FIRST) begin
        ctrl_first_r <= pwdata[7:0] & TW_CTRL_FIRST_WMASK;
      end
      if (paddr == TW_ADDR_CTRL_SECOND) begin
        waveform_mode_hi_r <= pwdata[TW_MODE_HI_BIT];
      end
    end
  end

  // compare registers: pwm modes double buffer so the period never glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_buf_r <= TW_CMP_RST;
      cmp_b_buf_r <= TW_CMP_RST;
      compare_value_a_r <= TW_CMP_RST;
      compare_value_b_r <= TW_CMP_RST;
    end else begin
      if (wr_en && paddr == TW_ADDR_CMP_A) begin
        cmp_a_buf_r <= pwdata[7:0];
      end
      if (wr_en && paddr == TW_ADDR_CMP_B) begin
        cmp_b_buf_r <= pwdata[7:0];
      end
      if (!pwm) begin
        if (wr_en && paddr == TW_ADDR_CMP_A) begin
          compare_value_a_r <= pwdata[7:0];
        end
        if (wr_en && paddr == TW_ADDR_CMP_B) begin
          compare_value_b_r <= pwdata[7:0];
        end
      end else if (tick_en && at_top) begin
        compare_value_a_r <= cmp_a_buf_r;
        compare_value_b_r <= cmp_b_buf_r;
      end
    end
  end

  // counting sequence per mode; reserved modes hold the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= TW_COUNT_RST;
      down_r <= 1'b0;
    end else if (wr_en && paddr == TW_ADDR_COUNT) begin
      count_value_r <= pwdata[7:0];
    end else if (tick_en) begin
      case (mode_class)
        TW_MC_NORMAL: count_value_r <= count_value_r + 8'h01;
        TW_MC_CTC, TW_MC_FAST: begin
          count_value_r <= at_top ? TW_BOTTOM : count_value_r + 8'h01;
          down_r <= 1'b0;
        end
        TW_MC_PHASE: begin
          if (!down_r && at_top) begin
            down_r <= 1'b1;
            count_value_r <= count_value_r - 8'h01;
          end else if (down_r && count_value_r == TW_BOTTOM) begin
            down_r <= 1'b0;
            count_value_r <= count_value_r + 8'h01;
          end else if (down_r) begin
            count_value_r <= count_value_r - 8'h01;
          end else begin
            count_value_r <= count_value_r + 8'h01;
          end
        end
        default: count_value_r <= count_value_r;
      endcase
    end
  end

  // a count write suppresses the match on the following tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (wr_en && paddr == TW_ADDR_COUNT) begin
      block_r <= 1'b1;
    end else if (tick_en) begin
      block_r <= 1'b0;
    end
  end

  always_comb begin
    case (waveform_mode_sel)
      3'h0, 3'h2, 3'h3: ovf_set = tick_en && count_value_r == TW_MAX;
      3'h1, 3'h5: ovf_set = tick_en && down_r && count_value_r == TW_BOTTOM;
      3'h7: ovf_set = tick_en && at_top;
      default: ovf_set = 1'b0;
    endcase
  end

  // write one clears; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_r <= 1'b1;
    end else if (wr_en && paddr == TW_ADDR_STATUS && pwdata[TW_OVF_BIT]) begin
      ovf_r <= 1'b0;
    end
  end

  assign overflow_flag = ovf_r;

  assign evt_a.match = (count_value_r == compare_value_a_r) && !block_r;
  assign evt_a.at_top = at_top;
  assign evt_a.down = down_r;
  assign evt_a.cmp_is_top = (compare_value_a_r == top_val);
  assign evt_b.match = (count_value_r == compare_value_b_r) && !block_r;
  assign evt_b.at_top = at_top;
  assign evt_b.down = down_r;
  assign evt_b.cmp_is_top = (compare_value_b_r == top_val);

  tw_out_unit #(.CHAN_A(1'b1)) u_out_a (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(timer_tick),
    .mode_class(mode_class),
    .mode_hi(waveform_mode_hi_r),
    .action(output_a_action),
    .evt(evt_a),
    .pin_dir(pin_dir_a),
    .wave_out(wave_out_a),
    .pin_oe(pin_oe_a)
  );

  tw_out_unit #(.CHAN_A(1'b0)) u_out_b (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(timer_tick),
    .mode_class(mode_class),
    .mode_hi(waveform_mode_hi_r),
    .action(output_b_action),
    .evt(evt_b),
    .pin_dir(pin_dir_b),
    .wave_out(wave_out_b),
    .pin_oe(pin_oe_b)
  );

  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_first_r[3:2] == 2'h0) else $error("reserved control bits nonzero");
  fast_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && mode_class == TW_MC_FAST && at_top && !wr_en
    |=> count_value_r == TW_BOTTOM) else $error("fast pwm did not clear at top");
  phase_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && mode_class == TW_MC_PHASE && !down_r && at_top && !wr_en
    |=> down_r && count_value_r == $past(count_value_r) - 8'h01)
    else $error("phase pwm did not turn at top");
  ovf_bottom_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && mode_class == TW_MC_PHASE && down_r && count_value_r == TW_BOTTOM
    |=> ovf_r) else $error("overflow not set at bottom");
  cmp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm && !(tick_en && at_top) && $past(pwm) |=> $stable(compare_value_a_r) or !pwm)
    else $error("pwm compare changed away from top");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable ##1 ce && psel && penable |=> pready)
    else $error("apb answer late");
  cov_ovf_c: cover property (@(posedge pclk) disable iff (!presetn)
    ovf_set && wr_en && paddr == TW_ADDR_STATUS);
  cov_mode5_c: cover property (@(posedge pclk) disable iff (!presetn)
    tick_en && waveform_mode_sel == 3'h5 && at_top);

  // counting, overflow and compare loading per mode, register writes and apb answer; writes excluded as they win
  ovf_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && waveform_mode_sel inside {3'h0, 3'h2, 3'h3} && count_value_r == TW_MAX
    |=> ovf_r) else $error("overflow not set at max");
  ovf_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && waveform_mode_sel == 3'h7 && at_top |=> ovf_r)
    else $error("overflow not set at top");
  ovf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ovf_set && wr_en && paddr == TW_ADDR_STATUS && pwdata[TW_OVF_BIT] |=> !ovf_r)
    else $error("overflow not cleared by write");
  normal_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && mode_class == TW_MC_NORMAL && !wr_en
    |=> count_value_r == $past(count_value_r) + 8'h01) else $error("normal count stuck");
  rsvd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && mode_class == TW_MC_RSVD && !wr_en
    |=> $stable(count_value_r) && !$rose(ovf_r))
    else $error("reserved mode moved the counter");
  top_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && waveform_mode_sel inside {3'h2, 3'h7} && count_value_r == compare_value_a_r
    && !wr_en |=> count_value_r == TW_BOTTOM) else $error("compare a not used as top");
  top_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && waveform_mode_sel inside {3'h1, 3'h3} && !down_r && !wr_en
    && count_value_r != TW_TOP_FIXED
    |=> count_value_r == $past(count_value_r) + 8'h01) else $error("count stopped below top");
  phase_bottom_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && mode_class == TW_MC_PHASE && down_r && count_value_r == TW_BOTTOM && !wr_en
    |=> !down_r && count_value_r == TW_BOTTOM + 8'h01) else $error("phase pwm did not turn up");
  cmp_imm_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == TW_ADDR_CMP_A && !pwm |=> compare_value_a_r == $past(pwdata[7:0]))
    else $error("compare a write not immediate");
  cmp_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && pwm && at_top |=> compare_value_a_r == $past(cmp_a_buf_r)
    && compare_value_b_r == $past(cmp_b_buf_r)) else $error("compare not loaded at top");
  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == TW_ADDR_CTRL_FIRST |=> ctrl_first_r[7:4] == $past(pwdata[7:4])
    && ctrl_first_r[1:0] == $past(pwdata[1:0])) else $error("control write lost");
  mode_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == TW_ADDR_CTRL_SECOND
    |=> waveform_mode_sel[2] == $past(pwdata[TW_MODE_HI_BIT])) else $error("mode high bit lost");
  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && pready |=> !pready) else $error("apb answer held too long");
  cov_ignore_c: cover property (@(posedge pclk) disable iff (!presetn)
    tick_en && pwm && evt_a.cmp_is_top && at_top && output_a_action[1]);
endmodule : tw_wave_ctrl
